//--- pkg/pmd_cfg.svh
/*
 Timing counts, thresholds, limits and reset values for the motion detector.
 Assumes a 20 MHz core clock; every derived count is worked out where it is used.
*/
`ifndef PMD_CFG_SVH
`define PMD_CFG_SVH

// core clock period and sampling tick period, in ns
`define PMD_CLK_NS        50
`define PMD_TICK_NS       52000
// self-test settle time per drive level, and the tick, in us
`define PMD_SETTLE_US     520
`define PMD_TICK_US       52
// decisions per evaluation window
`define PMD_WIN_TICKS     10'h3E8
// comparator threshold on the amplifier sample
`define PMD_THRESHOLD     8'h96
// slow frame length in ticks (one frame is 52 ms)
`define PMD_FRAME_TICKS   10'h3E8
// heartbeat and fault blink half periods, movement hold, in frames
`define PMD_HB_FRAMES     5'h0A
`define PMD_BLINK_FRAMES  5'h05
`define PMD_HOLD_FRAMES   6'h28
// collector level expected while the amplifier base is driven high
`define PMD_COLL_ON       1'b1
// baseline tracking step per window
`define PMD_BASE_STEP     10'h001
// reset values
`define PMD_COUNT_RST     10'h000
`define PMD_SPARE_RST     1'b1

`endif

//--- pkg/pmd_pkg.sv
/*
 Types shared by the motion detector modules.
 Assumes pmd_cfg.svh carries the numeric constants.
*/
`default_nettype none

package pmd_pkg;

   // self-test and operating phases
   typedef enum logic [1:0] {
      ST_SETTLE_HIGH,
      ST_SETTLE_LOW,
      ST_RUN,
      ST_FAIL
   } pmd_state_t;

   // window decision count
   typedef logic [9:0] pmd_count_t;

   // amplifier sample
   typedef logic [7:0] pmd_sample_t;

endpackage : pmd_pkg
`default_nettype wire

//--- src/pmd_motion_eval.sv
/*
 Window count evaluator: keeps a slowly tracking baseline and flags motion
 when a window count leaves the band around it in either signed direction.
 Assumes win_valid is a one-cycle pulse on the core clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pmd_cfg.svh"

module pmd_motion_eval
   import pmd_pkg::*;
(
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst,
   // window result
   input  wire logic       win_valid,
   input  wire pmd_count_t win_count,
   // band limits above and below the baseline
   input  wire pmd_count_t limit_up,
   input  wire pmd_count_t limit_down,
   // result
   output logic            motion_q,
   output pmd_count_t      baseline_q
);

   logic               first_q;
   logic signed [10:0] dev;
   logic signed [10:0] up_lim;
   logic signed [10:0] dn_lim;
   logic               too_high;
   logic               too_low;
   logic               outside;
   logic               step_up;
   logic               step_dn;
   pmd_count_t         baseline_d;

   // signed deviation: size and sign judged separately
   assign dev      = $signed({1'b0, win_count}) - $signed({1'b0, baseline_q});
   assign up_lim   = $signed({1'b0, limit_up});
   assign dn_lim   = $signed(11'h000) - $signed({1'b0, limit_down});
   assign too_high = dev > up_lim;
   assign too_low  = dev < dn_lim;
   assign outside  = win_valid && !first_q && (too_high || too_low);

   // baseline follows the drift one step per window, frozen during motion
   assign step_up    = !outside && (dev > $signed(11'h000));
   assign step_dn    = !outside && (dev < $signed(11'h000));
   assign baseline_d = first_q ? win_count :
                       step_up ? baseline_q + `PMD_BASE_STEP :
                       step_dn ? baseline_q - `PMD_BASE_STEP : baseline_q;

   // baseline, first-window seed and motion pulse
   always_ff @(posedge clk) begin
      if (rst) begin
         first_q    <= 1'b1;
         baseline_q <= `PMD_COUNT_RST;
         motion_q   <= 1'b0;
      end else begin
         motion_q <= outside;
         if (win_valid) begin
            first_q    <= 1'b0;
            baseline_q <= baseline_d;
         end
      end
   end

endmodule : pmd_motion_eval
`default_nettype wire

//--- src/pmd_detector.sv
/*
 Passive infrared motion detector control: one-bit bias feedback loop
 around the amplifier, window counting of low decisions, motion and
 tamper detection, power-on self-test and indicator drive.
 Assumes the ADC answers ADC_START with ADC_DONE on the core clock, and
 that the collector and tamper pins are asynchronous.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pmd_cfg.svh"

// Behaviour
// - bias bit holds amplifier output at threshold
// - count bias decisions while holding threshold
// - motion when count leaves configured band
// - judge drift by size and sign
// - tamper pin high means housing removed
// - self-test collector against base drive
// - fault indicator on during self-test
// - fault indicator blinks on test failure
// - spare indicator driven high, push-pull
// - heartbeat toggles during normal operation
// - tamper indicator on after tamper event
// - movement indicator on after motion
// - logic runs from one core clock
// - each tick compare sample with 96h
// - store low count every 1000 ticks
module pmd_detector
   import pmd_pkg::*;
(
   // clock and reset
   input  wire logic       CORE_CLK,
   input  wire logic       RESET,
   // converter handshake
   output logic            ADC_START,
   input  wire logic       ADC_DONE,
   input  wire pmd_sample_t ADC_DATA,
   // transistor circuitry
   output logic            AMPLIFIER_BASE_DRIVE,
   input  wire logic       OUTPUT_STAGE_COLLECTOR,
   // housing switch
   input  wire logic       TAMPER_SENSE_PIN,
   // motion band configuration
   input  wire pmd_count_t MOTION_LIMIT_UP,
   input  wire pmd_count_t MOTION_LIMIT_DOWN,
   // status
   output pmd_count_t      WINDOW_COUNT,
   output logic            WINDOW_VALID,
   output logic            MOTION_EVENT,
   output logic            TAMPER_ALARM,
   output logic            SELFTEST_BUSY,
   output logic            SELFTEST_FAIL,
   // indicators
   output logic            FAULT_INDICATOR,
   output logic            SPARE_INDICATOR,
   output logic            SPARE_INDICATOR_OE,
   output logic            HEARTBEAT_INDICATOR,
   output logic            TAMPER_INDICATOR,
   output logic            MOVEMENT_INDICATOR
);

   // derived counts
   localparam logic [10:0] TICK_LAST =
      11'(`PMD_TICK_NS / `PMD_CLK_NS - 1);
   localparam logic [7:0]  SETTLE_LAST =
      8'((`PMD_SETTLE_US + `PMD_TICK_US - 1) / `PMD_TICK_US - 1);
   localparam pmd_count_t  WIN_LAST   = `PMD_WIN_TICKS - 10'h001;
   localparam pmd_count_t  FRAME_LAST = `PMD_FRAME_TICKS - 10'h001;

   // synchronisers
   logic        coll_s1_q;
   logic        coll_s2_q;
   logic        tamp_s1_q;
   logic        tamp_s2_q;

   // timebase
   logic [10:0] tick_cnt_q;
   logic [10:0] tick_cnt_d;
   logic        tick;
   pmd_count_t  frame_cnt_q;
   pmd_count_t  frame_cnt_d;
   logic        frame_end;

   // self-test sequencer
   pmd_state_t  state_q;
   pmd_state_t  state_d;
   logic [7:0]  settle_q;
   logic [7:0]  settle_d;
   logic        settle_done;
   logic        run;
   logic        coll_ok_high;
   logic        coll_ok_low;

   // sigma-delta loop
   logic        bias_q;
   logic        bias_d;
   logic        below;
   logic        decide;
   pmd_count_t  win_cnt_q;
   pmd_count_t  win_cnt_d;
   pmd_count_t  low_cnt_q;
   pmd_count_t  low_cnt_d;
   pmd_count_t  low_sum;
   logic        win_end;
   logic        base_d;

   // indicators
   logic [4:0]  hb_cnt_q;
   logic [4:0]  hb_cnt_d;
   logic        hb_flip;
   logic [4:0]  blink_cnt_q;
   logic [4:0]  blink_cnt_d;
   logic        blink_flip;
   logic        blink_q;
   logic [5:0]  hold_q;
   logic [5:0]  hold_d;
   logic        fault_d;
   logic        motion_pulse;
   pmd_count_t  baseline;

   // two-stage synchronisers, only the second stage is used
   always_ff @(posedge CORE_CLK) begin
      if (RESET) begin
         coll_s1_q <= 1'b0;
         coll_s2_q <= 1'b0;
         tamp_s1_q <= 1'b0;
         tamp_s2_q <= 1'b0;
      end else begin
         coll_s1_q <= OUTPUT_STAGE_COLLECTOR;
         coll_s2_q <= coll_s1_q;
         tamp_s1_q <= TAMPER_SENSE_PIN;
         tamp_s2_q <= tamp_s1_q;
      end
   end

   // 52 us sampling tick and 52 ms frame from the core clock
   assign tick        = tick_cnt_q == TICK_LAST;
   assign tick_cnt_d  = tick ? 11'h000 : tick_cnt_q + 11'h001;
   assign frame_end   = tick && (frame_cnt_q == FRAME_LAST);
   assign frame_cnt_d = frame_end ? 10'h000 :
                        tick ? frame_cnt_q + 10'h001 : frame_cnt_q;

   // timebase counters
   always_ff @(posedge CORE_CLK) begin
      if (RESET) begin
         tick_cnt_q  <= 11'h000;
         frame_cnt_q <= 10'h000;
      end else begin
         tick_cnt_q  <= tick_cnt_d;
         frame_cnt_q <= frame_cnt_d;
      end
   end

   // self-test: drive base high then low, check collector after settling
   assign settle_done  = tick && (settle_q == SETTLE_LAST);
   assign settle_d     = (settle_done || state_q == ST_RUN) ? 8'h00 :
                         tick ? settle_q + 8'h01 : settle_q;
   assign coll_ok_high = coll_s2_q == `PMD_COLL_ON;
   assign coll_ok_low  = coll_s2_q == ~`PMD_COLL_ON;
   assign run          = state_q == ST_RUN;

   // next phase
   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_SETTLE_HIGH: begin
            if (settle_done) begin
               state_d = coll_ok_high ? ST_SETTLE_LOW : ST_FAIL;
            end
         end
         ST_SETTLE_LOW: begin
            if (settle_done) begin
               state_d = coll_ok_low ? ST_RUN : ST_FAIL;
            end
         end
         ST_RUN:  state_d = ST_RUN;
         ST_FAIL: state_d = ST_FAIL;
         default: state_d = ST_FAIL;
      endcase
   end

   // phase registers; every reset restarts the test
   always_ff @(posedge CORE_CLK) begin
      if (RESET) begin
         state_q  <= ST_SETTLE_HIGH;
         settle_q <= 8'h00;
      end else begin
         state_q  <= state_d;
         settle_q <= settle_d;
      end
   end

   // comparator decision; an equal sample counts as above
   assign below  = ADC_DATA < `PMD_THRESHOLD;
   assign decide = run && ADC_DONE;
   assign bias_d = decide ? below : bias_q;

   // window of decisions, low ones counted
   assign win_end   = decide && (win_cnt_q == WIN_LAST);
   assign low_sum   = low_cnt_q + {9'h000, ~below};
   assign win_cnt_d = win_end ? 10'h000 :
                      decide ? win_cnt_q + 10'h001 : win_cnt_q;
   assign low_cnt_d = win_end ? 10'h000 :
                      decide ? low_sum : low_cnt_q;

   // base drive follows the test phase, then the loop
   assign base_d = (state_q == ST_SETTLE_HIGH) ? 1'b1 :
                   (state_q == ST_SETTLE_LOW)  ? 1'b0 :
                   run ? bias_d : 1'b0;

   // loop registers and converter start
   always_ff @(posedge CORE_CLK) begin
      if (RESET) begin
         bias_q               <= 1'b0;
         win_cnt_q            <= 10'h000;
         low_cnt_q            <= 10'h000;
         ADC_START            <= 1'b0;
         AMPLIFIER_BASE_DRIVE <= 1'b0;
      end else begin
         bias_q               <= bias_d;
         win_cnt_q            <= win_cnt_d;
         low_cnt_q            <= low_cnt_d;
         ADC_START            <= run && tick;
         AMPLIFIER_BASE_DRIVE <= base_d;
      end
   end

   // stored window result
   always_ff @(posedge CORE_CLK) begin
      if (RESET) begin
         WINDOW_COUNT <= `PMD_COUNT_RST;
         WINDOW_VALID <= 1'b0;
      end else begin
         WINDOW_VALID <= win_end;
         if (win_end) begin
            WINDOW_COUNT <= low_sum;
         end
      end
   end

   // baseline tracking and band check
   pmd_motion_eval u_eval (
      .clk        (CORE_CLK),
      .rst        (RESET),
      .win_valid  (WINDOW_VALID),
      .win_count  (WINDOW_COUNT),
      .limit_up   (MOTION_LIMIT_UP),
      .limit_down (MOTION_LIMIT_DOWN),
      .motion_q   (motion_pulse),
      .baseline_q (baseline)
   );

   // heartbeat and blink half-period counters in frames
   assign hb_flip     = frame_end && (hb_cnt_q == `PMD_HB_FRAMES - 5'h01);
   assign hb_cnt_d    = hb_flip ? 5'h00 :
                        frame_end ? hb_cnt_q + 5'h01 : hb_cnt_q;
   assign blink_flip  = frame_end && (blink_cnt_q == `PMD_BLINK_FRAMES - 5'h01);
   assign blink_cnt_d = blink_flip ? 5'h00 :
                        frame_end ? blink_cnt_q + 5'h01 : blink_cnt_q;

   // movement hold reloads on every motion event
   assign hold_d = motion_pulse ? `PMD_HOLD_FRAMES :
                   (frame_end && hold_q != 6'h00) ? hold_q - 6'h01 : hold_q;

   // fault: steady during test, blinking on failure, dark in operation;
   // taken from the next phase so it moves in step with the busy flag
   assign fault_d = (state_d == ST_SETTLE_HIGH) || (state_d == ST_SETTLE_LOW) ||
                    (state_d == ST_FAIL && blink_q);

   // slow counters
   always_ff @(posedge CORE_CLK) begin
      if (RESET) begin
         hb_cnt_q    <= 5'h00;
         blink_cnt_q <= 5'h00;
         blink_q     <= 1'b1;
         hold_q      <= 6'h00;
      end else begin
         hb_cnt_q    <= hb_cnt_d;
         blink_cnt_q <= blink_cnt_d;
         blink_q     <= blink_flip ? ~blink_q : blink_q;
         hold_q      <= hold_d;
      end
   end

   // status and indicator flops
   always_ff @(posedge CORE_CLK) begin
      if (RESET) begin
         FAULT_INDICATOR     <= 1'b1;
         SPARE_INDICATOR     <= `PMD_SPARE_RST;
         SPARE_INDICATOR_OE  <= 1'b1;
         HEARTBEAT_INDICATOR <= 1'b0;
         TAMPER_INDICATOR    <= 1'b0;
         TAMPER_ALARM        <= 1'b0;
         MOVEMENT_INDICATOR  <= 1'b0;
         MOTION_EVENT        <= 1'b0;
         SELFTEST_BUSY       <= 1'b1;
         SELFTEST_FAIL       <= 1'b0;
      end else begin
         FAULT_INDICATOR     <= fault_d;
         SPARE_INDICATOR     <= 1'b1;
         SPARE_INDICATOR_OE  <= 1'b1;
         HEARTBEAT_INDICATOR <= run && (HEARTBEAT_INDICATOR ^ hb_flip);
         TAMPER_ALARM        <= tamp_s2_q;
         TAMPER_INDICATOR    <= TAMPER_INDICATOR || tamp_s2_q;
         MOVEMENT_INDICATOR  <= hold_d != 6'h00;
         MOTION_EVENT        <= motion_pulse;
         SELFTEST_BUSY       <= state_d == ST_SETTLE_HIGH ||
                                state_d == ST_SETTLE_LOW;
         SELFTEST_FAIL       <= state_d == ST_FAIL;
      end
   end

endmodule : pmd_detector
`default_nettype wire

//--- tb/pmd_detector_chk.sv
/*
 Assertions on the motion detector's top ports.
 Assumes one core clock and a synchronous active-high reset; bound from the bench.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pmd_cfg.svh"

module pmd_detector_chk
   import pmd_pkg::*;
(
   // clock and reset
   input wire logic        CORE_CLK,
   input wire logic        RESET,
   // converter loop
   input wire logic        ADC_START,
   input wire logic        ADC_DONE,
   input wire pmd_sample_t ADC_DATA,
   input wire logic        AMPLIFIER_BASE_DRIVE,
   // tamper
   input wire logic        TAMPER_SENSE_PIN,
   input wire logic        TAMPER_ALARM,
   input wire logic        TAMPER_INDICATOR,
   // self-test and indicators
   input wire logic        SELFTEST_BUSY,
   input wire logic        SELFTEST_FAIL,
   input wire logic        FAULT_INDICATOR,
   input wire logic        SPARE_INDICATOR,
   input wire logic        SPARE_INDICATOR_OE,
   input wire logic        HEARTBEAT_INDICATOR
);
   // one domain; reset cancels every check
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (RESET);
   // normal running once the self-test has passed
   wire run = !SELFTEST_BUSY && !SELFTEST_FAIL;

   // bias loop
   a_bias_follow: assert property (
      ADC_DONE && run |=> AMPLIFIER_BASE_DRIVE == ($past(ADC_DATA) < `PMD_THRESHOLD))
      else $error("bias bit does not follow the sample");
   a_start_run: assert property (ADC_START |-> run)
      else $error("conversion requested outside normal running");
   a_start_pulse: assert property (ADC_START |=> !ADC_START)
      else $error("conversion request longer than one cycle");
   // self-test and indicator lamps
   a_fault_test: assert property (SELFTEST_BUSY |-> FAULT_INDICATOR)
      else $error("fault lamp off during self-test");
   a_fault_run: assert property (run |-> !FAULT_INDICATOR)
      else $error("fault lamp on while running");
   a_fail_sticky: assert property (
      SELFTEST_FAIL |=> SELFTEST_FAIL && !SELFTEST_BUSY)
      else $error("failure flag not held");
   a_spare_high: assert property (SPARE_INDICATOR && SPARE_INDICATOR_OE)
      else $error("spare lamp not driven high");
   a_hb_quiet: assert property (!run |-> !HEARTBEAT_INDICATOR)
      else $error("heartbeat active outside running");
   // tamper
   a_tamper_sync: assert property (TAMPER_SENSE_PIN [*3] |=> TAMPER_ALARM)
      else $error("tamper alarm late");
   a_tamper_hold: assert property (TAMPER_INDICATOR |=> TAMPER_INDICATOR)
      else $error("tamper lamp dropped");
   a_alarm_lamp: assert property (TAMPER_ALARM |-> TAMPER_INDICATOR)
      else $error("tamper lamp off during alarm");

   // main scenarios reached
   c_decision: cover property (ADC_DONE && run);
   c_fail: cover property ($rose(SELFTEST_FAIL));
   c_tamper: cover property ($rose(TAMPER_ALARM));
endmodule : pmd_detector_chk
`default_nettype wire

//--- tb/pmd_amp_model.sv
/*
 Amplifier stage and converter as seen by the detector.
 Answers each request after a chosen lag; collector follows the base drive unless stuck holds it low.
*/
`timescale 1ns/1ps
`default_nettype none

module pmd_amp_model
   import pmd_pkg::*;
(
   // clock
   input wire logic        clk,
   // detector side
   input wire logic        adc_start,
   output logic            adc_done,
   output pmd_sample_t     adc_data,
   input wire logic        base_drive,
   output logic            collector,
   // bench controls
   input wire logic        stuck,
   input wire logic [1:0]  lag,
   input wire pmd_sample_t level
);
   int cnt = -1;

   // quiet outputs at time zero
   initial begin
      adc_done = 1'b0;
      adc_data = 8'h00;
      collector = 1'b0;
   end

   // one answer per request; data churns while not valid
   always @(negedge clk) begin
      adc_done <= 1'b0;
      adc_data <= ~adc_data;
      collector <= stuck ? 1'b0 : base_drive; // broken stage holds it low
      if (adc_start) begin
         cnt <= lag;
      end else if (cnt == 0) begin
         adc_done <= 1'b1;
         adc_data <= level;
         cnt <= -1;
      end else if (cnt > 0) begin
         cnt <= cnt - 1;
      end
   end
endmodule : pmd_amp_model
`default_nettype wire

//--- tb/pir_motion_detector_control_tb.sv
/*
 Self-checking bench for the motion detector top.
 Inputs change on the falling edge; an amplifier model answers conversions.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pmd_cfg.svh"

module pir_motion_detector_control_tb
   import pmd_pkg::*;
;
   logic        clk, rst, adc_start, adc_done, base, coll, tamper, stuck;
   logic        win_valid, motion, alarm, busy, fail, fault, spare, spare_oe, hb, tind, mind;
   pmd_sample_t adc_data, level;
   pmd_count_t  lim_up, lim_dn, win_count;
   logic [1:0]  lag;
   int          fails = 0;
   int          n_compared = 0;
   int          n;
   logic [31:0] seed = 32'hEBDF3614;
   bit          exp_q[$];

   // design and amplifier model
   pmd_detector u_pmd_detector (
      .CORE_CLK(clk), .RESET(rst), .ADC_START(adc_start), .ADC_DONE(adc_done),
      .ADC_DATA(adc_data), .AMPLIFIER_BASE_DRIVE(base), .OUTPUT_STAGE_COLLECTOR(coll),
      .TAMPER_SENSE_PIN(tamper), .MOTION_LIMIT_UP(lim_up), .MOTION_LIMIT_DOWN(lim_dn),
      .WINDOW_COUNT(win_count), .WINDOW_VALID(win_valid), .MOTION_EVENT(motion),
      .TAMPER_ALARM(alarm), .SELFTEST_BUSY(busy), .SELFTEST_FAIL(fail),
      .FAULT_INDICATOR(fault), .SPARE_INDICATOR(spare), .SPARE_INDICATOR_OE(spare_oe),
      .HEARTBEAT_INDICATOR(hb), .TAMPER_INDICATOR(tind), .MOVEMENT_INDICATOR(mind));
   pmd_amp_model u_pmd_amp_model (
      .clk(clk), .adc_start(adc_start), .adc_done(adc_done), .adc_data(adc_data),
      .base_drive(base), .collector(coll), .stuck(stuck), .lag(lag), .level(level));

   // 20 MHz core clock
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h00000000);
   endfunction : lfsr

   task automatic check(input logic [9:0] seen, input logic [9:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
      end
   endtask : check

   task automatic finish_test;
      if (fails == 0 && n_compared > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : finish_test

   // reset for two cycles, then count cycles until the self-test ends
   task automatic do_reset;
      rst = 1'b1;
      repeat (2) @(negedge clk);
      check({fault, spare, spare_oe, busy}, 10'h00F);
      check({adc_start, base, win_valid, motion, alarm, fail, hb, tind, mind}, 10'h000);
      check(win_count, 10'h000);
      rst = 1'b0;
      n = 0;
      while (busy === 1'b1 && n < 30000) begin
         @(negedge clk);
         n++;
         if (n == 10)
            check({9'h000, base}, 10'h001);
      end
   endtask : do_reset

   // main sequence
   initial begin
      rst = 1'b1;
      tamper = 1'b0;
      stuck = 1'b1;
      lag = 2'h0;
      level = 8'h00;
      seed = lfsr(seed);
      lim_up = seed[9:0];
      lim_dn = seed[19:10];
      // collector stuck low: the high phase ends in failure
      do_reset();
      check({9'h000, n > 10396 && n < 10404}, 10'h001);
      check({fail, fault, busy, adc_start}, 10'h00C);
      // healthy stage: both phases pass into running
      stuck = 1'b0;
      do_reset();
      check({9'h000, n > 20796 && n < 20804}, 10'h001);
      check({fail, fault, busy}, 10'h000);
      // samples around the threshold and random, prompt and slow answers
      for (int i = 0; i < 40; i++) begin
         seed = lfsr(seed);
         level = (i < 3) ? 8'h95 + i[7:0] : seed[7:0];
         lag = i[1:0];
         exp_q.push_back(level < `PMD_THRESHOLD);
         n = 0;
         do begin
            @(posedge clk);
            n++;
         end while (adc_done !== 1'b1 && n < 2000);
         @(negedge clk);
         check({9'h000, base}, {9'h000, exp_q.pop_front()});
      end
      // housing opened for a few cycles, then closed again
      tamper = 1'b1;
      repeat (3) @(negedge clk);
      check({alarm, tind}, 10'h003);
      tamper = 1'b0;
      repeat (4) @(negedge clk);
      check({alarm, tind}, 10'h001);
      check({spare, spare_oe}, 10'h003);
      finish_test();
   end

   // watchdog sized for two self-tests and the decision run
   initial begin
      repeat (90000) @(posedge clk);
      fails++;
      finish_test();
   end
endmodule : pir_motion_detector_control_tb

bind pmd_detector pmd_detector_chk u_pmd_detector_chk (
   .CORE_CLK(CORE_CLK), .RESET(RESET), .ADC_START(ADC_START), .ADC_DONE(ADC_DONE),
   .ADC_DATA(ADC_DATA), .AMPLIFIER_BASE_DRIVE(AMPLIFIER_BASE_DRIVE),
   .TAMPER_SENSE_PIN(TAMPER_SENSE_PIN), .TAMPER_ALARM(TAMPER_ALARM),
   .TAMPER_INDICATOR(TAMPER_INDICATOR), .SELFTEST_BUSY(SELFTEST_BUSY),
   .SELFTEST_FAIL(SELFTEST_FAIL), .FAULT_INDICATOR(FAULT_INDICATOR),
   .SPARE_INDICATOR(SPARE_INDICATOR), .SPARE_INDICATOR_OE(SPARE_INDICATOR_OE),
   .HEARTBEAT_INDICATOR(HEARTBEAT_INDICATOR));
`default_nettype wire
